//--- hw/tws_pkg.sv
// Constants shared by the two-wire configuration target.
package tws_pkg;
  localparam logic [5:0] TWS_ADDR_UPPER = 6'h26;
  localparam int TWS_DEGLITCH_CYC = 3;
  localparam int TWS_SYNC_STAGES = 3;
  localparam logic [7:0] TWS_PTR_RESET = 8'h00;
  localparam logic [3:0] TWS_ACK_BIT = 4'h8;
  typedef enum {TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_WRX, TWS_WR_ACK,
    TWS_RDX, TWS_RD_ACK, TWS_IGNORE} tws_state_type;
endpackage : tws_pkg

//--- hw/tws_config_slave.sv
// Two-wire serial target giving a host access to a register file.
module tws_config_slave
  import tws_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic addrSel,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] regAddr,
  output logic [DATA_W-1:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic [DATA_W-1:0] regRdData,
  output logic busBusy
);
  logic [TWS_SYNC_STAGES-1:0] sclSync_r;
  logic [TWS_SYNC_STAGES-1:0] sdaSync_r;
  logic sclFilt_r;
  logic sdaFilt_r;
  logic [1:0] glitchCnt_r;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic [TWS_SYNC_STAGES-1:0] strapSync_r;
  logic strap_r;
  logic addrSeen_r;
  tws_state_type state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic ptrLoaded_r;
  logic [7:0] rdShift_r;
  logic pullLow_r;
  logic hostNack_r;
  logic [6:0] ownAddr;

  // Strap pin synchronised; level taken once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (reset) strapSync_r <= '0;
    else strapSync_r <= {strapSync_r[TWS_SYNC_STAGES-2:0], addrSel};
  end
  always_ff @(posedge core_clk) begin
    if (reset) strap_r <= 1'b0;
    else if (strapSync_r[2] == strapSync_r[1]) strap_r <= strapSync_r[2];
  end
  assign ownAddr = {TWS_ADDR_UPPER, strap_r};

  // Three-stage synchronisers, preset high during reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclSync_r <= '1;
      sdaSync_r <= '1;
    end else begin
      sclSync_r <= {sclSync_r[TWS_SYNC_STAGES-2:0], sclIn};
      sdaSync_r <= {sdaSync_r[TWS_SYNC_STAGES-2:0], sdaIn};
    end
  end

  // Deglitch: clock must stay at the new level for three cycles
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclFilt_r <= 1'b1;
      glitchCnt_r <= 2'h0;
    end else if (sclSync_r[2] == sclSync_r[1] && sclSync_r[2] != sclFilt_r)
        begin
      if (glitchCnt_r == 2'(TWS_DEGLITCH_CYC - 1)) begin
        sclFilt_r <= sclSync_r[2];
        glitchCnt_r <= 2'h0;
      end else begin
        glitchCnt_r <= glitchCnt_r + 2'h1;
      end
    end else begin
      glitchCnt_r <= 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) sdaFilt_r <= 1'b1;
    else if (sdaSync_r[2] == sdaSync_r[1]) sdaFilt_r <= sdaSync_r[2];
  end

  logic sclNew;
  logic sdaNew;
  assign sclNew = (glitchCnt_r == 2'(TWS_DEGLITCH_CYC - 1)) &&
    sclSync_r[2] == sclSync_r[1] && sclSync_r[2] != sclFilt_r;
  assign sdaNew = (sdaSync_r[2] == sdaSync_r[1]) ? sdaSync_r[2] : sdaFilt_r;
  assign sclRise = sclNew && !sclFilt_r;
  assign sclFall = sclNew && sclFilt_r;
  assign startDet = sclFilt_r && !sclNew && sdaFilt_r && !sdaNew;
  assign stopDet = sclFilt_r && !sclNew && !sdaFilt_r && sdaNew;

  // Falling clock that closes a start is no address bit
  always_ff @(posedge core_clk) begin
    if (reset) addrSeen_r <= 1'b0;
    else if (startDet) addrSeen_r <= 1'b0;
    else if (sclRise) addrSeen_r <= 1'b1;
  end

  // Bus state machine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= TWS_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      busBusy <= 1'b0;
    end else if (startDet) begin
      state_r <= TWS_ADDR;
      bitCnt_r <= 4'h0;
      busBusy <= 1'b1;
    end else if (stopDet) begin
      state_r <= TWS_IDLE;
      busBusy <= 1'b0;
    end else if (sclRise) begin
      if (bitCnt_r != TWS_ACK_BIT) shift_r <= {shift_r[6:0], sdaFilt_r};
      if (state_r == TWS_RD_ACK && bitCnt_r == TWS_ACK_BIT) begin
        bitCnt_r <= bitCnt_r;
      end
    end else if (sclFall && (state_r != TWS_ADDR || addrSeen_r)) begin
      case (state_r)
        TWS_ADDR, TWS_WRX, TWS_RDX: begin
          if (bitCnt_r == 4'h7) begin
            bitCnt_r <= TWS_ACK_BIT;
            if (state_r == TWS_ADDR)
              state_r <= (shift_r[7:1] == ownAddr) ? TWS_ADDR_ACK
                : TWS_IGNORE;
            else if (state_r == TWS_WRX) state_r <= TWS_WR_ACK;
            else state_r <= TWS_RD_ACK;
          end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
          end
        end
        TWS_ADDR_ACK: begin
          bitCnt_r <= 4'h0;
          state_r <= shift_r[0] ? TWS_RDX : TWS_WRX;
        end
        TWS_WR_ACK: begin
          bitCnt_r <= 4'h0;
          state_r <= TWS_WRX;
        end
        TWS_RD_ACK: begin
          bitCnt_r <= 4'h0;
          state_r <= hostNack_r ? TWS_IGNORE : TWS_RDX;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Host acknowledge sampled in the ninth clock of a read byte
  always_ff @(posedge core_clk) begin
    if (reset) hostNack_r <= 1'b0;
    else if (sclRise && state_r == TWS_RD_ACK) hostNack_r <= sdaFilt_r;
  end

  // Pointer load, data write and auto-increment
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_r <= TWS_PTR_RESET;
      ptrLoaded_r <= 1'b0;
      regWrData <= '0;
      regWrStb <= 1'b0;
    end else begin
      regWrStb <= 1'b0;
      if (startDet) begin
        ptrLoaded_r <= 1'b0;
      end else if (sclFall && state_r == TWS_WRX && bitCnt_r == 4'h7) begin
        if (!ptrLoaded_r) begin
          ptr_r <= shift_r;
          ptrLoaded_r <= 1'b1;
        end else begin
          regWrData <= DATA_W'(shift_r);
          regWrStb <= 1'b1;
        end
      end else if (regWrStb) begin
        ptr_r <= ptr_r + 8'h01;
      end else if (regRdStb) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end
  assign regAddr = ptr_r;

  // Read data fetch and shift, changed only after falling edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdShift_r <= 8'hFF;
      regRdStb <= 1'b0;
    end else begin
      regRdStb <= 1'b0;
      if (sclFall && (state_r == TWS_ADDR_ACK && shift_r[0] ||
          state_r == TWS_RD_ACK && !hostNack_r)) begin
        rdShift_r <= 8'(regRdData);
        regRdStb <= 1'b1;
      end else if (sclFall && state_r == TWS_RDX && bitCnt_r != 4'h7) begin
        rdShift_r <= {rdShift_r[6:0], 1'b1};
      end
    end
  end

  // Open-drain drive: acknowledge or read data zero
  always_ff @(posedge core_clk) begin
    if (reset) pullLow_r <= 1'b0;
    else if (startDet || stopDet) pullLow_r <= 1'b0;
    else if (sclFall) begin
      if (state_r == TWS_ADDR && bitCnt_r == 4'h7)
        pullLow_r <= (shift_r[7:1] == ownAddr);
      else if (state_r == TWS_WRX && bitCnt_r == 4'h7)
        pullLow_r <= 1'b1;
      else if (state_r == TWS_ADDR_ACK && shift_r[0] ||
          state_r == TWS_RD_ACK && !hostNack_r)
        pullLow_r <= !regRdData[7];
      else if (state_r == TWS_RDX && bitCnt_r != 4'h7)
        pullLow_r <= !rdShift_r[6];
      else pullLow_r <= 1'b0;
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOe = pullLow_r;

  a_ack_on_match: assert property (@(posedge core_clk) disable iff (reset)
    sclFall && state_r == TWS_ADDR && bitCnt_r == 4'h7 &&
    shift_r[7:1] == ownAddr && !startDet && !stopDet |=> sdaOe)
    else $error("no acknowledge on address match");
  a_no_drive_high: assert property (@(posedge core_clk) disable iff (reset)
    sdaOe |-> !sdaOut)
    else $error("data line driven high");
  a_sda_change_fall: assert property (@(posedge core_clk) disable iff (reset)
    $changed(sdaOe) |-> $past(sclFall) || $past(startDet) ||
    $past(stopDet))
    else $error("data line changed off falling edge");
  a_wr_ptr_inc: assert property (@(posedge core_clk) disable iff (reset)
    regWrStb && !startDet |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer not advanced after write");
  a_idle_after_stop: assert property (@(posedge core_clk) disable iff (reset)
    stopDet && !startDet |=> state_r == TWS_IDLE && !sdaOe)
    else $error("stop did not end transfer");
  a_start_addr: assert property (@(posedge core_clk) disable iff (reset)
    startDet |=> state_r == TWS_ADDR && bitCnt_r == 4'h0)
    else $error("start not detected");
  a_idle_ignores: assert property (@(posedge core_clk) disable iff (reset)
    state_r == TWS_IDLE && !startDet |=> !regWrStb && !regRdStb)
    else $error("activity before start");
  a_addr_value: assert property (@(posedge core_clk) disable iff (reset)
    ownAddr == (strap_r ? 7'h4D : 7'h4C))
    else $error("bus address wrong");
  a_deglitch_three: assert property (@(posedge core_clk) disable iff (reset)
    sclRise |-> $past(sclSync_r[2], 1) && $past(sclSync_r[2], 2))
    else $error("clock edge not deglitched");
  c_write_byte: cover property (@(posedge core_clk) regWrStb);
  c_read_byte: cover property (@(posedge core_clk) regRdStb);
  c_restart: cover property (@(posedge core_clk) startDet && busBusy);
  c_nomatch: cover property (@(posedge core_clk) state_r == TWS_IGNORE);
endmodule : tws_config_slave

//--- dv/tws_host_model.sv
// Behavioural two-wire bus host: drives the clock, pulls data low.
module tws_host_model (
  output logic sclPin,
  output logic sdaPull,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 80;
  initial begin
    sclPin = 1'b1;
    sdaPull = 1'b0;
  end
  // Data moves mid-low, sampled at end of high
  task automatic bitCycle(input logic b, output logic got);
    sclPin = 1'b0;
    #HALF sdaPull = !b;
    #HALF sclPin = 1'b1;
    #(2*HALF) got = sdaLine;
  endtask : bitCycle
  task automatic startCond();
    sclPin = 1'b0;
    #HALF sdaPull = 1'b0;
    #HALF sclPin = 1'b1;
    #(2*HALF) sdaPull = 1'b1;
    #(2*HALF);
  endtask : startCond
  task automatic stopCond();
    sclPin = 1'b0;
    #HALF sdaPull = 1'b1;
    #HALF sclPin = 1'b1;
    #(2*HALF) sdaPull = 1'b0;
    #(2*HALF);
  endtask : stopCond
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(d[i], r);
    end
    bitCycle(1'b1, r);
    ack = !r;
  endtask : sendByte
  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, d[i]);
    end
    bitCycle(!ackIt, r);
  endtask : recvByte
endmodule : tws_host_model

//--- dv/test_two_wire_config_slave.sv
// Self-checking bench for the two-wire configuration target.
module test_two_wire_config_slave;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, addrSel, sclPin, sdaPull, sdaOut, sdaOe;
  logic regWrStb, regRdStb, busBusy, ack;
  logic [7:0] regAddr, regWrData, regRdData, rd;
  logic [7:0] mem [256];
  wire logic sdaLine;
  int bad_count = 0;
  int n_checks = 0;
  int nRdStb = 0;
  assign sdaLine = !(sdaPull | sdaOe); // Pull-up on data
  assign regRdData = mem[regAddr];
  always @(posedge core_clk) begin
    if (regWrStb === 1'b1) begin
      mem[regAddr] <= regWrData;
    end
  end
  tws_config_slave u_dut (.core_clk(core_clk), .reset(reset),
    .addrSel(addrSel), .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .busBusy(busBusy));
  tws_host_model u_host (.sclPin(sclPin), .sdaPull(sdaPull),
    .sdaLine(sdaLine));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  always @(negedge core_clk) begin
    if (sdaOe === 1'b1) begin
      chk({7'h00, sdaOut}, 8'h00);
    end
    if (regRdStb === 1'b1) begin
      nRdStb++;
    end
  end
  task automatic writeBurst();
    u_host.startCond();
    chk({7'h00, busBusy}, 8'h01);
    u_host.sendByte({7'h4C, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    u_host.sendByte(8'hFE, ack);
    u_host.sendByte(8'h11, ack);
    u_host.sendByte(8'h22, ack);
    u_host.sendByte(8'h33, ack);
    u_host.stopCond();
    chk({7'h00, busBusy}, 8'h00);
    chk(mem[8'hFE], 8'h11);
    chk(mem[8'hFF], 8'h22);
    chk(mem[8'h00], 8'h33);
    chk(regAddr, 8'h01);
  endtask : writeBurst
  task automatic readBurst();
    u_host.startCond();
    u_host.sendByte(8'h98, ack);
    u_host.sendByte(8'hFE, ack);
    u_host.startCond();
    u_host.sendByte(8'h99, ack);
    chk({7'h00, ack}, 8'h01);
    u_host.recvByte(1'b1, rd);
    chk(rd, 8'h11);
    u_host.recvByte(1'b1, rd);
    chk(rd, 8'h22);
    u_host.recvByte(1'b0, rd);
    chk(rd, 8'h33);
    u_host.stopCond();
    chk(8'(nRdStb), 8'h03);
    chk(regAddr, 8'h01);
  endtask : readBurst
  task automatic strapCase(input logic s, input logic [7:0] a,
                           input logic expAck, input logic [7:0] p);
    @(negedge core_clk) addrSel = s;
    repeat (8) @(negedge core_clk);
    u_host.startCond();
    u_host.sendByte(a, ack);
    chk({7'h00, ack}, {7'h00, expAck});
    u_host.sendByte(p, ack);
    u_host.sendByte(8'hA5, ack);
    u_host.stopCond();
    chk(mem[p], expAck ? 8'hA5 : (p ^ 8'h5A));
  endtask : strapCase
  task automatic noStart();
    u_host.sendByte(8'h98, ack);
    chk({7'h00, ack}, 8'h00);
    u_host.sendByte(8'h06, ack);
    u_host.sendByte(8'h99, ack);
    u_host.stopCond();
    chk(mem[8'h06], 8'h5C);
  endtask : noStart
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    addrSel = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    repeat (8) @(negedge core_clk);
    writeBurst();
    readBurst();
    strapCase(1'b0, 8'h9A, 1'b0, 8'h05);
    strapCase(1'b1, 8'h9A, 1'b1, 8'h40);
    strapCase(1'b1, 8'h98, 1'b0, 8'h41);
    strapCase(1'b0, 8'h98, 1'b1, 8'h42);
    noStart();
    give_verdict();
  end
endmodule : test_two_wire_config_slave
